// ==== tb/iepc_cpu_model.sv ====
/*
  Core-side model: accepts a request once per rise and keeps its vector.
  Assumes the block holds cpu_irq_req as a level while pending.
*/
module iepc_cpu_model
  import iepc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Request from the block, and the accept enable from the testbench
  input wire logic cpu_irq_req,
  input wire logic [7:0] cpu_irq_vector,
  input wire logic ack_allow,
  // Acceptance
  output logic irq_ack,
  output logic [7:0] taken_vector
);
  logic req_d;
  // One pulse per rise; a held level is never accepted twice
  wire take = ack_allow && cpu_irq_req && !req_d;
  always_ff @(posedge core_clk)
  begin
    req_d <= cpu_irq_req;
    irq_ack <= take && !srst;
    if (srst)
      taken_vector <= 8'h00;
    else if (take)
      taken_vector <= cpu_irq_vector;
  end
endmodule

// ==== tb/iepc_properties.sv ====
/*
  Checker for iepc_top: enable gating, vector order, serial control bits.
  Assumes bound to iepc_top; register writes land at waitrequest low.
*/
module iepc_properties
  import iepc_pkg::*;
(
  // Clock, reset and bus
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [IEPC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  // Sources
  input wire logic ext_irq0_flag,
  input wire logic timer0_overflow_flag,
  input wire logic ext_irq1_flag,
  input wire logic timer1_overflow_flag,
  input wire logic output_buffer_full_flag,
  input wire logic rx_done_flag,
  input wire logic tx_done_flag,
  input wire logic input_buffer_full_flag,
  input wire logic host_read_strobe_n,
  input wire logic [1:0] serial_mode,
  input wire logic serial_baud_from_timer1,
  // Outputs
  input wire logic cpu_irq_req,
  input wire logic [7:0] cpu_irq_vector,
  input wire logic serial_baud_x2,
  input wire logic frame_error_flag,
  input wire logic irq
);
  localparam logic [9:0] A_IE = {IEPC_IDX_IRQ_ENABLE, 2'b00};
  localparam logic [9:0] A_PC = {IEPC_IDX_POWER_CTRL, 2'b00};
  localparam logic [9:0] A_SC = {IEPC_IDX_SERIAL_CTRL, 2'b00};
  logic [7:0] ie_s;
  logic [7:0] pc_s;
  wire wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
  // Output buffer left out: its request hangs on the synchronised strobe
  wire [6:0] req = {input_buffer_full_flag, rx_done_flag | tx_done_flag, 1'b0, timer1_overflow_flag,
    ext_irq1_flag, timer0_overflow_flag, ext_irq0_flag} & {ie_s[5], ie_s[4], ie_s[6], ie_s[3:0]};
  wire ob_quiet = !(ie_s[6] && output_buffer_full_flag);
  wire [7:0] exp_vec = req[0] ? IEPC_VEC_EXT0 : req[1] ? IEPC_VEC_TIMER0 : req[2] ? IEPC_VEC_EXT1 :
    req[3] ? IEPC_VEC_TIMER1 : req[5] ? IEPC_VEC_SERIAL : IEPC_VEC_INBUF;
  wire x2_exp = pc_s[7] && serial_mode != 2'h0 && serial_baud_from_timer1;
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ie_s <= 8'h00;
      pc_s <= 8'h00;
    end
    else if (wr_done && avs_address == A_IE)
      ie_s <= avs_writedata[7:0];
    else if (wr_done && avs_address == A_PC)
      pc_s <= avs_writedata[7:0];
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_global_off; !ie_s[7] |=> !cpu_irq_req; endproperty
  a_global_off: assert property (p_global_off) else $error("request with global enable clear");
  property p_source_gate; ie_s[7] && ob_quiet |=> cpu_irq_req == $past(|req); endproperty
  a_source_gate: assert property (p_source_gate) else $error("request differs from enables");
  property p_outbuf_read;
    ie_s[7:6] == 2'b11 && output_buffer_full_flag && $rose(host_read_strobe_n) |-> ##[1:8] cpu_irq_req;
  endproperty
  a_outbuf_read: assert property (p_outbuf_read) else $error("no request after host read");
  property p_vector_order; ie_s[7] && ob_quiet && |req |=> cpu_irq_vector == $past(exp_vec); endproperty
  a_vector_order: assert property (p_vector_order) else $error("wrong vector");
  property p_baud_x2;
    $stable(pc_s) && $stable(serial_mode) && $stable(serial_baud_from_timer1) |-> serial_baud_x2 == x2_exp;
  endproperty
  a_baud_x2: assert property (p_baud_x2) else $error("baud doubling wrong");
  property p_fe_read;
    avs_read && !avs_waitrequest && avs_address == A_SC && pc_s[6] |-> avs_readdata[7] == frame_error_flag;
  endproperty
  a_fe_read: assert property (p_fe_read) else $error("serial bit seven not frame error");
  property p_reset_clear; disable iff (1'b0) srst |=> !cpu_irq_req && !irq && !serial_baud_x2; endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("output set after reset");
  c_outbuf: cover property (cpu_irq_req && cpu_irq_vector == IEPC_VEC_OUTBUF);
  c_unmapped: cover property (!avs_waitrequest && avs_response == 2'h3);
  c_x2: cover property (serial_baud_x2);
endmodule
bind iepc_top iepc_properties u_props (.*);

// ==== tb/irq_enable_and_power_ctrl_test.sv ====
/*
  Testbench for iepc_top: register tasks over Avalon-MM, source flags, core model.
  Assumes the checker is bound through its own file.
*/
module irq_enable_and_power_ctrl_test
  import iepc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] A_IE = {IEPC_IDX_IRQ_ENABLE, 2'b00};
  localparam logic [9:0] A_PC = {IEPC_IDX_POWER_CTRL, 2'b00};
  localparam logic [9:0] A_SC = {IEPC_IDX_SERIAL_CTRL, 2'b00};
  localparam logic [9:0] A_ST = {IEPC_IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] A_MK = {IEPC_IDX_IRQ_MASK, 2'b00};
  localparam logic [7:0] VT [6] = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B};
  localparam logic [7:0] EN [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20};
  localparam logic [7:0] MK [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'hA0, 8'h40};
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [IEPC_ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0, avs_write = 1'b0, host_read_strobe_n = 1'b1;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'h1;
  logic [7:0] src = 8'h00;
  logic [1:0] serial_mode = 2'h0;
  logic serial_baud_from_timer1 = 1'b0, frame_error_event = 1'b0, ack_allow = 1'b0;
  logic [31:0] avs_readdata;
  logic [1:0] avs_response, rsp;
  logic [7:0] cpu_irq_vector, taken_vector, q;
  logic avs_waitrequest, cpu_irq_req, serial_baud_x2, serial_mode_bit0, frame_error_flag;
  logic idle_mode, power_down_mode, irq, irq_ack;
  wire logic ext_irq0_flag = src[0];
  wire logic timer0_overflow_flag = src[1];
  wire logic ext_irq1_flag = src[2];
  wire logic timer1_overflow_flag = src[3];
  wire logic output_buffer_full_flag = src[4];
  wire logic rx_done_flag = src[5];
  wire logic input_buffer_full_flag = src[6];
  wire logic tx_done_flag = src[7];
  int miscompares = 0;
  int total_checks = 0;
  int n;
  always #25 core_clk = ~core_clk;
  iepc_top DUT (.*);
  iepc_cpu_model u_cpu (.*);
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // Holds the request until waitrequest is sampled low, then one idle edge
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d, output logic [7:0] r);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= wr;
    avs_read <= !wr;
    for (n = 0; n < 50; n++)
    begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (n == 50)
    begin
      miscompares++;
      report_and_stop();
    end
    r = avs_readdata[7:0];
    rsp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  initial
  begin
    step(10);
    srst <= 1'b0;
    step(1);
    bus(0, A_IE, 8'h00, q);
    chk("enable reset", IEPC_IE_RESET, q);
    bus(0, A_PC, 8'h00, q);
    chk("power reset", IEPC_POWER_CTRL_REG_RESET, q);
    bus(0, 10'h004, 8'h00, q);
    chk("unmapped", 8'h03, {6'h00, rsp});
    bus(1, A_IE, 8'h7F, q);
    src <= 8'hEF;
    step(4);
    chk("gated", 8'h00, {7'h00, cpu_irq_req});
    for (int i = 0; i < 6; i++)
    begin
      bus(1, A_IE, 8'h80 | EN[i], q);
      step(3);
      chk("single vector", VT[i], cpu_irq_vector);
    end
    src <= 8'h00;
    bus(1, A_IE, 8'hFF, q);
    ack_allow <= 1'b1;
    src <= 8'hEF;
    step(4);
    ack_allow <= 1'b0;
    chk("taken", VT[0], taken_vector);
    for (int i = 0; i < 6; i++)
    begin
      chk("order vector", VT[i], cpu_irq_vector);
      src <= src & ~MK[i];
      step(3);
    end
    bus(0, A_ST, 8'h00, q);
    chk("status", 8'h6F, q);
    chk("irq open", 8'h01, {7'h00, irq});
    bus(1, A_MK, 8'hFF, q);
    step(2);
    chk("irq masked", 8'h00, {7'h00, irq});
    bus(1, A_MK, 8'h00, q);
    bus(1, A_ST, 8'hFF, q);
    step(2);
    chk("irq cleared", 8'h00, {7'h00, irq});
    bus(1, A_IE, 8'hC0, q);
    src <= 8'h30;
    host_read_strobe_n <= 1'b0;
    step(4);
    host_read_strobe_n <= 1'b1;
    for (n = 0; n < 20 && cpu_irq_req !== 1'b1; n++)
      step(1);
    chk("outbuf request", 8'h01, {7'h00, cpu_irq_req});
    if (n == 20)
      report_and_stop();
    bus(1, A_IE, 8'hD0, q);
    step(3);
    chk("outbuf first", IEPC_VEC_OUTBUF, cpu_irq_vector);
    bus(1, A_IE, 8'h90, q);
    step(3);
    chk("outbuf blocked", IEPC_VEC_SERIAL, cpu_irq_vector);
    src <= 8'h00;
    bus(1, A_PC, 8'h80, q);
    serial_baud_from_timer1 <= 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      serial_mode <= m[1:0];
      step(3);
      chk("baud x2", {7'h00, m != 0}, {7'h00, serial_baud_x2});
    end
    serial_baud_from_timer1 <= 1'b0;
    step(3);
    chk("baud no timer", 8'h00, {7'h00, serial_baud_x2});
    bus(1, A_PC, 8'h40, q);
    frame_error_event <= 1'b1;
    step(1);
    frame_error_event <= 1'b0;
    step(2);
    chk("frame flag", 8'h01, {7'h00, frame_error_flag});
    bus(0, A_SC, 8'h00, q);
    chk("serial bit7", 8'h80, q & 8'h80);
    bus(1, A_PC, 8'h00, q);
    bus(1, A_SC, 8'h80, q);
    step(2);
    chk("mode bit0", 8'h01, {7'h00, serial_mode_bit0});
    bus(1, A_PC, 8'h03, q);
    bus(0, A_PC, 8'h00, q);
    chk("pd wins", 8'h02, q);
    chk("power down", 8'h01, {7'h00, power_down_mode});
    chk("idle off", 8'h00, {7'h00, idle_mode});
    bus(1, A_PC, 8'h01, q);
    step(2);
    chk("idle on", 8'h01, {7'h00, idle_mode});
    report_and_stop();
  end
endmodule

// ==== verilog/iepc_pkg.sv ====
/*
  Package for the interrupt enable, vectoring and power control block:
  register offsets, bit positions, reset values and vector addresses.
  Assumes a 32-bit Avalon-MM register bus with word-aligned byte addresses.
*/
package iepc_pkg;

  // Register indices (printed offsets are not all multiples of four,
  // so each is an index and the byte address is four times it)
  localparam logic [7:0] IEPC_IDX_POWER_CTRL = 8'h87;
  localparam logic [7:0] IEPC_IDX_IRQ_ENABLE = 8'hA8;
  localparam logic [7:0] IEPC_IDX_SERIAL_CTRL = 8'h98;
  localparam logic [7:0] IEPC_IDX_IRQ_STATUS = 8'hF8;
  localparam logic [7:0] IEPC_IDX_IRQ_MASK = 8'hF9;
  localparam logic [7:0] IEPC_IDX_VECTOR = 8'hFA;
  localparam int IEPC_ADDR_W = 10;

  // Interrupt enable register bits
  localparam int IEPC_BIT_GLOBAL_EN = 7;
  localparam int IEPC_BIT_OUTBUF_EN = 6;
  localparam int IEPC_BIT_INBUF_EN = 5;
  localparam int IEPC_BIT_SERIAL_EN = 4;
  localparam int IEPC_BIT_TIMER1_EN = 3;
  localparam int IEPC_BIT_EXT1_EN = 2;
  localparam int IEPC_BIT_TIMER0_EN = 1;
  localparam int IEPC_BIT_EXT0_EN = 0;

  // Power control register bits
  localparam int IEPC_BIT_BAUD_DOUBLER = 7;
  localparam int IEPC_BIT_FE_SELECT = 6;
  localparam int IEPC_BIT_POWER_OFF = 4;
  localparam int IEPC_BIT_POWER_DOWN = 1;
  localparam int IEPC_BIT_IDLE = 0;
  localparam logic [7:0] IEPC_POWER_CTRL_REG_WMASK = 8'hCF;
  localparam logic [7:0] IEPC_POWER_CTRL_REG_RESET = 8'h00;
  localparam logic [7:0] IEPC_IE_RESET = 8'h00;

  // Serial control register bit 7
  localparam int IEPC_BIT_SCON7 = 7;

  // Source numbers in polling order, highest first
  localparam int IEPC_NSRC = 7;
  localparam int IEPC_SRC_EXT0 = 0;
  localparam int IEPC_SRC_TIMER0 = 1;
  localparam int IEPC_SRC_EXT1 = 2;
  localparam int IEPC_SRC_TIMER1 = 3;
  localparam int IEPC_SRC_OUTBUF = 4;
  localparam int IEPC_SRC_SERIAL = 5;
  localparam int IEPC_SRC_INBUF = 6;

  localparam logic [7:0] IEPC_VEC_EXT0 = 8'h03;
  localparam logic [7:0] IEPC_VEC_TIMER0 = 8'h0B;
  localparam logic [7:0] IEPC_VEC_EXT1 = 8'h13;
  localparam logic [7:0] IEPC_VEC_TIMER1 = 8'h1B;
  localparam logic [7:0] IEPC_VEC_OUTBUF = 8'h33;
  localparam logic [7:0] IEPC_VEC_SERIAL = 8'h23;
  localparam logic [7:0] IEPC_VEC_INBUF = 8'h2B;

  // Serial modes
  localparam logic [1:0] IEPC_SMODE_SHIFT = 2'h0;

endpackage

// ==== verilog/iepc_sync.sv ====
/*
  Three-stage synchroniser with agreement filter for pin inputs.
  Assumes the input is asynchronous to core_clk.
*/
module iepc_sync
  import iepc_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Pins and filtered result
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] agree;

  // A change counts only once stages two and three agree
  assign agree = ~(stage2 ^ stage3);

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
      level_out <= RESET_VAL;
    end
    else
    begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level_out <= (agree & stage3) | (~agree & level_out);
    end
  end

endmodule

// ==== verilog/iepc_top.sv ====
/*
  Interrupt enable, polling priority and vector selection, plus the power
  control register, for a small 8-bit core. Registers sit on Avalon-MM.
  Assumes source flags come from logic on core_clk, except the host read
  strobe, which is a pin and is synchronised here.
*/
// Chosen here: register access over Avalon-MM.
// Operation
// - Global enable clear blocks every request
// - Global enable set gates each source separately
// - Host read strobe raises output-buffer interrupt
// - Fixed polling order picks a fixed vector
// - Baud doubler doubles timer-one serial rate outside shift mode
// - Frame error select swaps serial bit seven
module iepc_top
  import iepc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Avalon-MM slave
  input wire logic [IEPC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // Request flags from the sources
  input wire logic ext_irq0_flag,
  input wire logic timer0_overflow_flag,
  input wire logic ext_irq1_flag,
  input wire logic timer1_overflow_flag,
  input wire logic output_buffer_full_flag,
  input wire logic rx_done_flag,
  input wire logic tx_done_flag,
  input wire logic input_buffer_full_flag,
  // Host port pin
  input wire logic host_read_strobe_n,
  // Serial port context
  input wire logic [1:0] serial_mode,
  input wire logic serial_baud_from_timer1,
  input wire logic frame_error_event,
  // CPU core side
  input wire logic irq_ack,
  output logic cpu_irq_req,
  output logic [7:0] cpu_irq_vector,
  output logic serial_baud_x2,
  output logic serial_mode_bit0,
  output logic frame_error_flag,
  output logic idle_mode,
  output logic power_down_mode,
  // Interrupt to software
  output logic irq
);

  // Registers
  logic [7:0] irq_enable_reg;
  logic [7:0] power_ctrl_reg;
  logic fe_store;
  logic sm0_store;
  logic [IEPC_NSRC-1:0] irq_status;
  logic [IEPC_NSRC-1:0] irq_mask;
  logic outbuf_read_seen;
  logic strobe_prev;
  logic acc_done;

  function automatic logic [7:0] vec_of(input logic [IEPC_NSRC-1:0] pend);
    logic [7:0] v;
    v = '0;
    for (int i = IEPC_NSRC - 1; i >= 0; i--)
    begin
      if (pend[i])
      begin
        unique case (i)
          IEPC_SRC_EXT0: v = IEPC_VEC_EXT0;
          IEPC_SRC_TIMER0: v = IEPC_VEC_TIMER0;
          IEPC_SRC_EXT1: v = IEPC_VEC_EXT1;
          IEPC_SRC_TIMER1: v = IEPC_VEC_TIMER1;
          IEPC_SRC_OUTBUF: v = IEPC_VEC_OUTBUF;
          IEPC_SRC_SERIAL: v = IEPC_VEC_SERIAL;
          default: v = IEPC_VEC_INBUF;
        endcase
      end
    end
    return v;
  endfunction

  function automatic logic idx_is(input logic [IEPC_ADDR_W-1:0] a, input logic [7:0] idx);
    return a == {idx, 2'b00};
  endfunction

  // Host strobe synchroniser
  logic strobe_sync;
  iepc_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_strobe_sync
  (
    .core_clk(core_clk),
    .srst(srst),
    .pin_in(host_read_strobe_n),
    .level_out(strobe_sync)
  );

  // Rising edge of the strobe ends the host read of the output buffer
  wire strobe_done = strobe_sync & ~strobe_prev;

  // Address decode
  wire access = (avs_read | avs_write) & ~acc_done;
  wire sel_power_ctrl_reg = idx_is(avs_address, IEPC_IDX_POWER_CTRL);
  wire sel_ie = idx_is(avs_address, IEPC_IDX_IRQ_ENABLE);
  wire sel_serial_ctrl_reg = idx_is(avs_address, IEPC_IDX_SERIAL_CTRL);
  wire sel_stat = idx_is(avs_address, IEPC_IDX_IRQ_STATUS);
  wire sel_mask = idx_is(avs_address, IEPC_IDX_IRQ_MASK);
  wire sel_vec = idx_is(avs_address, IEPC_IDX_VECTOR);
  wire mapped = sel_power_ctrl_reg | sel_ie | sel_serial_ctrl_reg | sel_stat | sel_mask | sel_vec;
  // Writes commit at the edge where the master sees waitrequest low
  wire xfer = (avs_read | avs_write) & ~avs_waitrequest;
  wire wr_lane0 = xfer & avs_write & avs_byteenable[0];
  wire [7:0] wbyte = avs_writedata[7:0];

  // Per-source pending requests
  wire [IEPC_NSRC-1:0] raw_req;
  assign raw_req[IEPC_SRC_EXT0] = ext_irq0_flag;
  assign raw_req[IEPC_SRC_TIMER0] = timer0_overflow_flag;
  assign raw_req[IEPC_SRC_EXT1] = ext_irq1_flag;
  assign raw_req[IEPC_SRC_TIMER1] = timer1_overflow_flag;
  assign raw_req[IEPC_SRC_OUTBUF] = output_buffer_full_flag & outbuf_read_seen;
  assign raw_req[IEPC_SRC_SERIAL] = rx_done_flag | tx_done_flag;
  assign raw_req[IEPC_SRC_INBUF] = input_buffer_full_flag;

  wire [IEPC_NSRC-1:0] src_en;
  assign src_en[IEPC_SRC_EXT0] = irq_enable_reg[IEPC_BIT_EXT0_EN];
  assign src_en[IEPC_SRC_TIMER0] = irq_enable_reg[IEPC_BIT_TIMER0_EN];
  assign src_en[IEPC_SRC_EXT1] = irq_enable_reg[IEPC_BIT_EXT1_EN];
  assign src_en[IEPC_SRC_TIMER1] = irq_enable_reg[IEPC_BIT_TIMER1_EN];
  assign src_en[IEPC_SRC_OUTBUF] = irq_enable_reg[IEPC_BIT_OUTBUF_EN];
  assign src_en[IEPC_SRC_SERIAL] = irq_enable_reg[IEPC_BIT_SERIAL_EN];
  assign src_en[IEPC_SRC_INBUF] = irq_enable_reg[IEPC_BIT_INBUF_EN];

  wire global_irq_enable = irq_enable_reg[IEPC_BIT_GLOBAL_EN];
  wire [IEPC_NSRC-1:0] pend = raw_req & src_en & {IEPC_NSRC{global_irq_enable}};
  wire [7:0] next_vector = vec_of(pend);
  wire next_req = |pend;

  // Serial side effects
  wire fe_sel = power_ctrl_reg[IEPC_BIT_FE_SELECT];
  wire next_x2 = power_ctrl_reg[IEPC_BIT_BAUD_DOUBLER] & serial_baud_from_timer1
    & (serial_mode != IEPC_SMODE_SHIFT);
  wire [7:0] serial_ctrl_reg_rd = {fe_sel ? fe_store : sm0_store, 7'h00};

  // Status events: every pending source is set when the core acknowledges
  wire [IEPC_NSRC-1:0] ev_set = pend & ~({IEPC_NSRC{cpu_irq_req}} & ~pend) & {IEPC_NSRC{irq_ack}};
  wire [IEPC_NSRC-1:0] clr_stat = (wr_lane0 & sel_stat) ? avs_writedata[IEPC_NSRC-1:0] : '0;

  // PD wins when both power bits written together
  wire [7:0] power_ctrl_reg_w0 = (power_ctrl_reg & ~IEPC_POWER_CTRL_REG_WMASK) | (wbyte & IEPC_POWER_CTRL_REG_WMASK);
  wire [7:0] power_ctrl_reg_w = (power_ctrl_reg_w0[IEPC_BIT_POWER_DOWN]) ? (power_ctrl_reg_w0 & ~(8'h01 << IEPC_BIT_IDLE)) : power_ctrl_reg_w0;

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    if (sel_power_ctrl_reg)
      rd_mux[7:0] = power_ctrl_reg;
    else if (sel_ie)
      rd_mux[7:0] = irq_enable_reg;
    else if (sel_serial_ctrl_reg)
      rd_mux[7:0] = serial_ctrl_reg_rd;
    else if (sel_stat)
      rd_mux[IEPC_NSRC-1:0] = irq_status;
    else if (sel_mask)
      rd_mux[IEPC_NSRC-1:0] = irq_mask;
    else if (sel_vec)
      rd_mux[7:0] = cpu_irq_vector;
  end

  // Bus answer: one wait cycle, then done
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      acc_done <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
      avs_response <= 2'b00;
    end
    else
    begin
      acc_done <= access;
      avs_waitrequest <= ~access;
      if (access)
      begin
        avs_readdata <= avs_read ? rd_mux : '0;
        avs_response <= mapped ? 2'b00 : 2'b11;
      end
    end
  end

  // Software registers
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      irq_enable_reg <= IEPC_IE_RESET;
      power_ctrl_reg <= IEPC_POWER_CTRL_REG_RESET;
      irq_mask <= '0;
      sm0_store <= 1'b0;
    end
    else
    begin
      if (wr_lane0 & sel_ie)
        irq_enable_reg <= wbyte;
      if (wr_lane0 & sel_power_ctrl_reg)
        power_ctrl_reg <= power_ctrl_reg_w;
      if (wr_lane0 & sel_mask)
        irq_mask <= wbyte[IEPC_NSRC-1:0];
      if (wr_lane0 & sel_serial_ctrl_reg & ~fe_sel)
        sm0_store <= wbyte[IEPC_BIT_SCON7];
    end
  end

  // Hardware-set flags: set wins over the software clear
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      fe_store <= 1'b0;
      irq_status <= '0;
      strobe_prev <= 1'b1;
      outbuf_read_seen <= 1'b0;
    end
    else
    begin
      strobe_prev <= strobe_sync;
      irq_status <= (irq_status & ~clr_stat) | ev_set;
      // Frame error bit only cleared by software writing zero
      if (frame_error_event)
        fe_store <= 1'b1;
      else if (wr_lane0 & sel_serial_ctrl_reg & fe_sel & ~wbyte[IEPC_BIT_SCON7])
        fe_store <= 1'b0;
      // Armed by a host read; dropped once the buffer is no longer full
      if (strobe_done)
        outbuf_read_seen <= 1'b1;
      else if (~output_buffer_full_flag)
        outbuf_read_seen <= 1'b0;
    end
  end

  // Outputs to the core, all registered
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      cpu_irq_req <= 1'b0;
      cpu_irq_vector <= '0;
      serial_baud_x2 <= 1'b0;
      serial_mode_bit0 <= 1'b0;
      frame_error_flag <= 1'b0;
      idle_mode <= 1'b0;
      power_down_mode <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      cpu_irq_req <= next_req;
      cpu_irq_vector <= next_vector;
      serial_baud_x2 <= next_x2;
      serial_mode_bit0 <= sm0_store;
      frame_error_flag <= fe_store;
      idle_mode <= power_ctrl_reg[IEPC_BIT_IDLE];
      power_down_mode <= power_ctrl_reg[IEPC_BIT_POWER_DOWN];
      // Mask bit set hides its status bit
      irq <= |(irq_status & ~irq_mask);
    end
  end

endmodule
